// >>> gds_defs.svh
`ifndef GDS_DEFS_SVH
`define GDS_DEFS_SVH

// Register indices; byte address is four times the index
`define GDS_IDX_WARN 4'h1
`define GDS_IDX_FAULT 4'h3
`define GDS_IDX_OPER 4'h9
`define GDS_IDX_REGUL 4'hB
`define GDS_IDX_STATE 4'hE

// Warning and watchdog restart register fields
`define GDS_W_ANY_FAULT 10
`define GDS_W_TEMP4 8
`define GDS_W_LOW_WARN 7
`define GDS_W_HIGH_WARN 6
`define GDS_W_TEMP1 3
`define GDS_W_TEMP2 2
`define GDS_W_TEMP3 1
`define GDS_W_OVERHEAT_WARN 0

// Latched fault register fields
`define GDS_F_LOCKOUT 10
`define GDS_F_WATCHDOG 9
`define GDS_F_OVERHEAT 8
`define GDS_F_REGUL_UV 6
`define GDS_F_LOW_GATE_UV 4
`define GDS_F_PUMP_UV 2
`define GDS_F_PUMP_REL_OV 1
`define GDS_F_PUMP_ABS_OV 0

// Operation control register fields
`define GDS_O_LOCKOUT_DIS 9
`define GDS_O_WD_INT_HI 6
`define GDS_O_WD_INT_LO 5
`define GDS_O_WATCHDOG_ENABLE 3
`define GDS_O_SLEEP 2
`define GDS_O_CLEAR 1
`define GDS_O_WMASK 11'h26C
`define GDS_O_RESET 11'h000

// Regulator control register fields
`define GDS_R_SLP_HI 4
`define GDS_R_SLP_LO 3
`define GDS_R_MON_DIS 2
`define GDS_R_THR_HI 1
`define GDS_R_THR_LO 0
`define GDS_R_RESET 5'h00

// Timing
`define GDS_CLK_MHZ 250
`define GDS_PG_LOW_US 56
`define GDS_WD_INT0_MS 10
`define GDS_WD_INT1_MS 20
`define GDS_WD_INT2_MS 50
`define GDS_WD_INT3_MS 100
`define GDS_SLP_DLY0_US 10
`define GDS_SLP_DLY1_US 50
`define GDS_SLP_DLY2_US 100
`define GDS_SLP_DLY3_US 1000

`endif

// >>> gds_pkg.sv
package gds_pkg;

	// Comparator and flag levels from the analog side, active high
	typedef struct packed {
		logic main_supply_low_warning;
		logic main_supply_high_warning;
		logic main_supply_lockout;
		logic pump_relative_overvoltage;
		logic pump_absolute_overvoltage;
		logic pump_undervoltage;
		logic low_gate_supply_undervoltage;
		logic temp_level_one;
		logic temp_level_two;
		logic temp_level_three;
		logic temp_level_four;
		logic overheat_warning;
		logic overheat_shutdown;
		logic regulator_undervoltage;
	} gds_sense_t;

	typedef enum logic [2:0] {
		GDS_PWRUP = 3'h0,
		GDS_STBY = 3'h1,
		GDS_OPER = 3'h3,
		GDS_SLP_WAIT = 3'h5,
		GDS_SLEEP = 3'h4
	} gds_state_t;

endpackage

// >>> gds_fault_supervisor.sv
`timescale 1ns/1ps
`include "gds_defs.svh"
// Summary of operation
// - Main supply low warning pulls fault pin, shows live in warning register bit 7.
// - Main supply lockout latches fault bit 10, pulls fault pin, stops gate drive.
// - Lockout disable bit stops the lockout shutdown but the fault bit still latches.
// - Main supply high warning pulls fault pin, shows live in warning bit 6.
// - Pump relative and absolute overvoltage latch fault bits 1 and 0.
// - Pump or low gate supply undervoltage latch bits 2 or 4, stop gate drive.
// - Four temperature levels show live in warning bits 3,2,1,8, never on fault pin.
// - Overheat warning pulls fault pin and shows live in warning bit 0.
// - Overheat shutdown latches fault bit 8, pulls fault pin, stops gate drive.
// - Bus and registers keep working; overheat fault clears only when cool and commanded.
// - Watchdog is off after reset, enabled only by software writing its enable bit.
// - Enabled watchdog counts selected interval; each warning register read restarts it.
// - Watchdog expiry latches fault, makes gates safe, pulses power good low 56 us.
// - Watchdog expiry pulls fault pin, clears enable bit, sets fault bit 9.
// - Regulator threshold from bits 1-0; monitor off when bit 2 set.
// - Regulator undervoltage latches fault, power good low while present plus 56 us.
// - Regulator fault clears, once gone, by clear command or gate enable pulse.
// - At power-up pull gates down, drive fault pin low until lockout released.
// - Standby while gate enable low or any fault other than a disabled lockout; gates pulled down there.
// - Gate enable rising edge in standby enters operating when no fault other than a disabled lockout is latched.
// - Any fault except a disabled lockout returns operating to standby at once.
// - Sleep request accepted only in standby, powers down after selected delay.
// - Wake leaves sleep only above lockout, ignored awake; sleep erases control registers.
// - Faults hold fault pin low latched, warnings only while present; gates pulled low.

module gds_fault_supervisor #(
	parameter logic [31:0] PG_LOW_CYC = 32'(`GDS_PG_LOW_US * `GDS_CLK_MHZ),
	parameter logic [31:0] WD_CYC0 = 32'(`GDS_WD_INT0_MS * 1000 * `GDS_CLK_MHZ),
	parameter logic [31:0] WD_CYC1 = 32'(`GDS_WD_INT1_MS * 1000 * `GDS_CLK_MHZ),
	parameter logic [31:0] WD_CYC2 = 32'(`GDS_WD_INT2_MS * 1000 * `GDS_CLK_MHZ),
	parameter logic [31:0] WD_CYC3 = 32'(`GDS_WD_INT3_MS * 1000 * `GDS_CLK_MHZ),
	parameter logic [31:0] SLP_CYC0 = 32'(`GDS_SLP_DLY0_US * `GDS_CLK_MHZ),
	parameter logic [31:0] SLP_CYC1 = 32'(`GDS_SLP_DLY1_US * `GDS_CLK_MHZ),
	parameter logic [31:0] SLP_CYC2 = 32'(`GDS_SLP_DLY2_US * `GDS_CLK_MHZ),
	parameter logic [31:0] SLP_CYC3 = 32'(`GDS_SLP_DLY3_US * `GDS_CLK_MHZ)
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire gds_pkg::gds_sense_t sense,
	input wire logic gate_enable,
	input wire logic wake,
	input wire logic fault_out_n_in,
	output logic fault_out_n_out,
	output logic fault_out_n_oe_n,
	output logic power_good_out,
	output logic gate_drive_on,
	output logic gate_pulldown_on,
	output logic regulator_on,
	output logic [1:0] regulator_low_threshold
);

	localparam int SYNC_W = $bits(gds_pkg::gds_sense_t) + 3;
	localparam logic [10:0] O_WMASK = `GDS_O_WMASK;
	// Reset as if still locked out, so power-up is not left before the pins are sampled
	localparam gds_pkg::gds_sense_t SENSE_IDLE = '{main_supply_lockout: 1'b1, default: 1'b0};
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {SENSE_IDLE, 3'h0};

	// Two-stage synchronisers for every asynchronous pin
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
		end else begin
			sync1_q <= {sense, gate_enable, wake, fault_out_n_in};
			sync2_q <= sync1_q;
		end
	end

	gds_pkg::gds_sense_t s;
	logic gate_en_s;
	logic wake_s;
	logic fault_pin_s;
	assign s = gds_pkg::gds_sense_t'(sync2_q[SYNC_W-1:3]);
	assign gate_en_s = sync2_q[2];
	assign wake_s = sync2_q[1];
	assign fault_pin_s = sync2_q[0];

	gds_pkg::gds_state_t state_q;
	gds_pkg::gds_state_t state_d;
	logic [10:0] faults_q;
	logic [10:0] oper_q;
	logic [4:0] regul_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic gate_en_prev_q;
	logic [31:0] wd_cnt_q;
	logic wd_expire_q;
	logic wd_armed_q;
	logic [31:0] pg_cnt_q;
	logic [31:0] slp_cnt_q;
	logic pg_q;
	logic fault_oe_n_q;
	logic fault_out_q;
	logic gate_on_q;
	logic pulldown_q;
	logic reg_on_q;

	// Bus decode
	logic req;
	logic mapped;
	logic [3:0] idx;
	logic wr_lo;
	logic wr_hi;
	assign req = wb_cyc & wb_stb & ~ack_q;
	assign idx = wb_adr[5:2];
	assign mapped = (wb_adr[7:6] == 2'h0) && (idx == `GDS_IDX_WARN || idx == `GDS_IDX_FAULT
		|| idx == `GDS_IDX_OPER || idx == `GDS_IDX_REGUL || idx == `GDS_IDX_STATE);
	assign wr_lo = req & wb_we & wb_sel[0];
	assign wr_hi = req & wb_we & wb_sel[1];

	logic wr_oper;
	logic wr_regul;
	logic status_read;
	logic clear_cmd;
	logic sleep_accept;
	assign wr_oper = (wr_lo | wr_hi) && idx == `GDS_IDX_OPER && wb_adr[7:6] == 2'h0;
	assign wr_regul = wr_lo && idx == `GDS_IDX_REGUL && wb_adr[7:6] == 2'h0;
	assign status_read = req & ~wb_we && idx == `GDS_IDX_WARN && wb_adr[7:6] == 2'h0;
	assign clear_cmd = wr_oper & wr_lo & wb_dat_w[`GDS_O_CLEAR];
	// Sleep request outside standby is dropped
	assign sleep_accept = wr_oper & wr_lo & wb_dat_w[`GDS_O_SLEEP] & (state_q == gds_pkg::GDS_STBY);

	// Live fault conditions
	logic reg_uv_live;
	logic [10:0] cond;
	logic lockout_mask;
	assign reg_uv_live = s.regulator_undervoltage & ~regul_q[`GDS_R_MON_DIS] & reg_on_q;
	// Lockout is the normal state during power-up and sleep, not a fault there
	assign lockout_mask = (state_q == gds_pkg::GDS_PWRUP) || (state_q == gds_pkg::GDS_SLEEP);

	always_comb begin
		cond = '0;
		cond[`GDS_F_LOCKOUT] = s.main_supply_lockout & ~lockout_mask;
		cond[`GDS_F_WATCHDOG] = wd_expire_q;
		cond[`GDS_F_OVERHEAT] = s.overheat_shutdown;
		cond[`GDS_F_REGUL_UV] = reg_uv_live;
		cond[`GDS_F_LOW_GATE_UV] = s.low_gate_supply_undervoltage;
		cond[`GDS_F_PUMP_UV] = s.pump_undervoltage;
		cond[`GDS_F_PUMP_REL_OV] = s.pump_relative_overvoltage;
		cond[`GDS_F_PUMP_ABS_OV] = s.pump_absolute_overvoltage;
	end

	// Clearing: only bits whose condition has gone; a new event still wins
	logic gate_en_rise;
	logic [10:0] clr_mask;
	assign gate_en_rise = gate_en_s & ~gate_en_prev_q;

	always_comb begin
		clr_mask = clear_cmd ? ~cond : '0;
		if (gate_en_rise && !reg_uv_live) begin
			clr_mask[`GDS_F_REGUL_UV] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			faults_q <= '0;
			gate_en_prev_q <= 1'b0;
		end else begin
			faults_q <= (faults_q & ~clr_mask) | cond;
			gate_en_prev_q <= gate_en_s;
		end
	end

	// Faults that force standby
	logic shutdown;
	logic [10:0] shut_mask;
	always_comb begin
		shut_mask = '1;
		shut_mask[`GDS_F_LOCKOUT] = ~oper_q[`GDS_O_LOCKOUT_DIS];
	end
	assign shutdown = |(faults_q & shut_mask);

	logic any_warn;
	assign any_warn = s.main_supply_low_warning | s.main_supply_high_warning | s.overheat_warning;

	// Watchdog
	logic [31:0] wd_reload;
	always_comb begin
		case (oper_q[`GDS_O_WD_INT_HI:`GDS_O_WD_INT_LO])
			2'h0: wd_reload = WD_CYC0;
			2'h1: wd_reload = WD_CYC1;
			2'h2: wd_reload = WD_CYC2;
			default: wd_reload = WD_CYC3;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wd_cnt_q <= 32'h0000_0000;
			wd_expire_q <= 1'b0;
			wd_armed_q <= 1'b0;
		end else begin
			wd_expire_q <= 1'b0;
			// One cycle late so the first interval uses the newly written select
			wd_armed_q <= oper_q[`GDS_O_WATCHDOG_ENABLE];
			if (!oper_q[`GDS_O_WATCHDOG_ENABLE] || !wd_armed_q) begin
				wd_cnt_q <= wd_reload;
			end else if (status_read) begin
				wd_cnt_q <= wd_reload;
			end else if (wd_cnt_q <= 32'h0000_0001) begin
				wd_cnt_q <= wd_reload;
				wd_expire_q <= 1'b1;
			end else begin
				wd_cnt_q <= wd_cnt_q - 32'h0000_0001;
			end
		end
	end

	// Control registers; sleep entry erases them
	always_ff @(posedge sys_clk) begin
		if (rst || state_q == gds_pkg::GDS_SLEEP) begin
			oper_q <= `GDS_O_RESET;
			regul_q <= `GDS_R_RESET;
		end else begin
			if (wr_oper) begin
				if (wr_lo) begin
					oper_q[7:0] <= wb_dat_w[7:0] & O_WMASK[7:0];
					oper_q[`GDS_O_SLEEP] <= sleep_accept;
				end
				if (wr_hi) begin
					oper_q[10:8] <= wb_dat_w[10:8] & O_WMASK[10:8];
				end
			end
			if (wd_expire_q) begin
				oper_q[`GDS_O_WATCHDOG_ENABLE] <= 1'b0;
			end
			if (wr_regul) begin
				regul_q <= wb_dat_w[4:0];
			end
		end
	end

	// Operating state sequence
	logic [31:0] slp_reload;
	always_comb begin
		case (regul_q[`GDS_R_SLP_HI:`GDS_R_SLP_LO])
			2'h0: slp_reload = SLP_CYC0;
			2'h1: slp_reload = SLP_CYC1;
			2'h2: slp_reload = SLP_CYC2;
			default: slp_reload = SLP_CYC3;
		endcase
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			gds_pkg::GDS_PWRUP: begin
				if (!s.main_supply_lockout) begin
					state_d = gds_pkg::GDS_STBY;
				end
			end
			gds_pkg::GDS_STBY: begin
				if (sleep_accept) begin
					state_d = gds_pkg::GDS_SLP_WAIT;
				end else if (gate_en_rise && !shutdown) begin
					state_d = gds_pkg::GDS_OPER;
				end
			end
			gds_pkg::GDS_OPER: begin
				if (!gate_en_s || shutdown) begin
					state_d = gds_pkg::GDS_STBY;
				end
			end
			gds_pkg::GDS_SLP_WAIT: begin
				if (slp_cnt_q <= 32'h0000_0001) begin
					state_d = gds_pkg::GDS_SLEEP;
				end
			end
			gds_pkg::GDS_SLEEP: begin
				if (wake_s && !s.main_supply_lockout) begin
					state_d = gds_pkg::GDS_PWRUP;
				end
			end
			default: state_d = gds_pkg::GDS_PWRUP;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= gds_pkg::GDS_PWRUP;
			slp_cnt_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			if (state_q != gds_pkg::GDS_SLP_WAIT) begin
				slp_cnt_q <= slp_reload;
			end else begin
				slp_cnt_q <= slp_cnt_q - 32'h0000_0001;
			end
		end
	end

	// Power good: low for a fixed time, stretched while regulator is low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pg_cnt_q <= 32'h0000_0000;
			pg_q <= 1'b0;
		end else begin
			if (wd_expire_q || reg_uv_live) begin
				pg_cnt_q <= PG_LOW_CYC;
			end else if (pg_cnt_q != 32'h0000_0000) begin
				pg_cnt_q <= pg_cnt_q - 32'h0000_0001;
			end
			pg_q <= (pg_cnt_q == 32'h0000_0000) && !wd_expire_q && !reg_uv_live && state_q != gds_pkg::GDS_SLEEP;
		end
	end

	// Pins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fault_oe_n_q <= 1'b0;
			fault_out_q <= 1'b0;
			gate_on_q <= 1'b0;
			pulldown_q <= 1'b1;
			reg_on_q <= 1'b1;
		end else begin
			fault_out_q <= 1'b0;
			// Open drain: enable low means the pin is pulled low
			fault_oe_n_q <= ~((state_q == gds_pkg::GDS_PWRUP) | (|faults_q) | any_warn);
			// A disabled lockout must not stop the drive through the live condition either
			gate_on_q <= (state_d == gds_pkg::GDS_OPER) && !shutdown && !(|(cond & shut_mask));
			pulldown_q <= (state_d != gds_pkg::GDS_OPER) || shutdown || (|(cond & shut_mask));
			reg_on_q <= state_d != gds_pkg::GDS_SLEEP;
		end
	end

	// Read data
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		case (idx)
			`GDS_IDX_WARN: begin
				rd[`GDS_W_ANY_FAULT] = |faults_q;
				rd[`GDS_W_TEMP4] = s.temp_level_four;
				rd[`GDS_W_LOW_WARN] = s.main_supply_low_warning;
				rd[`GDS_W_HIGH_WARN] = s.main_supply_high_warning;
				rd[`GDS_W_TEMP1] = s.temp_level_one;
				rd[`GDS_W_TEMP2] = s.temp_level_two;
				rd[`GDS_W_TEMP3] = s.temp_level_three;
				rd[`GDS_W_OVERHEAT_WARN] = s.overheat_warning;
			end
			`GDS_IDX_FAULT: rd[10:0] = faults_q;
			`GDS_IDX_OPER: rd[10:0] = oper_q;
			`GDS_IDX_REGUL: rd[4:0] = regul_q;
			`GDS_IDX_STATE: rd[4:0] = {pg_q, fault_pin_s, state_q};
			default: rd = 32'h0000_0000;
		endcase
		if (wb_adr[7:6] != 2'h0 || !mapped) begin
			rd = 32'h0000_0000;
		end
	end

	// Single wait-free answer; bus stays live in every state
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !wb_we) begin
				dat_q <= rd;
			end
		end
	end

	assign wb_ack = ack_q;
	assign wb_dat_r = dat_q;
	assign fault_out_n_out = fault_out_q;
	assign fault_out_n_oe_n = fault_oe_n_q;
	assign power_good_out = pg_q;
	assign gate_drive_on = gate_on_q;
	assign gate_pulldown_on = pulldown_q;
	assign regulator_on = reg_on_q;
	assign regulator_low_threshold = regul_q[`GDS_R_THR_HI:`GDS_R_THR_LO];

endmodule

// >>> gds_fault_supervisor_checker.sv
`timescale 1ns/1ps
module gds_fault_supervisor_checker #(
	parameter logic [31:0] PG_LOW_CYC = 32'h14
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_ack,
	input wire gds_pkg::gds_sense_t sense,
	input wire logic gate_enable,
	input wire logic fault_out_n_out,
	input wire logic fault_out_n_oe_n,
	input wire logic power_good_out,
	input wire logic gate_drive_on,
	input wire logic gate_pulldown_on
);
	logic [31:0] pg_cnt_q;
	logic pg_q;
	// Length of the current low span of power good; preset to PG_LOW_CYC at reset so release is not a short pulse
	always_ff @(posedge sys_clk) begin
		pg_q <= power_good_out;
		if (rst)
			pg_cnt_q <= PG_LOW_CYC;
		else if (!power_good_out)
			pg_cnt_q <= pg_q ? 32'h1 : pg_cnt_q + 32'h1;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence s_req;
		wb_cyc && wb_stb && !wb_ack;
	endsequence
	sequence s_stop;
		(sense.pump_undervoltage || sense.low_gate_supply_undervoltage || sense.overheat_shutdown) [*3];
	endsequence
	sequence s_pump_ov;
		(sense.pump_relative_overvoltage || sense.pump_absolute_overvoltage) [*3];
	endsequence
	sequence s_warn;
		(sense.main_supply_low_warning || sense.main_supply_high_warning || sense.overheat_warning) [*3];
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> wb_ack) else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
	AST_FAULT_STOP: assert property (s_stop |-> ##[0:4] !gate_drive_on) else $error("gate drive kept on");
	AST_PUMP_OV_PIN: assert property (s_pump_ov |-> ##[0:4] !fault_out_n_oe_n) else $error("fault pin idle");
	AST_WARN_PIN: assert property (s_warn |-> ##[0:4] !fault_out_n_oe_n) else $error("warning not shown");
	AST_STBY_GE: assert property (!gate_enable [*3] |-> ##[0:4] !gate_drive_on) else $error("drive without enable");
	AST_GE_RISE: assert property ($rose(gate_drive_on) |-> $past(gate_enable, 3)) else $error("drive rose alone");
	AST_PULL_XOR: assert property (gate_drive_on != gate_pulldown_on) else $error("pull-down overlap");
	AST_PG_SPAN: assert property ($rose(power_good_out) |-> pg_cnt_q >= PG_LOW_CYC) else $error("power good pulse short");
	AST_OPEN_DRAIN: assert property (fault_out_n_out == 1'b0) else $error("fault pin driven high");
endmodule

bind gds_fault_supervisor gds_fault_supervisor_checker #(.PG_LOW_CYC(PG_LOW_CYC)) u_checker (
	.sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack), .sense(sense),
	.gate_enable(gate_enable), .fault_out_n_out(fault_out_n_out), .fault_out_n_oe_n(fault_out_n_oe_n),
	.power_good_out(power_good_out), .gate_drive_on(gate_drive_on), .gate_pulldown_on(gate_pulldown_on)
);

// >>> gds_mcu_model.sv
`timescale 1ns/1ps
module gds_mcu_model (
	input wire logic sys_clk,
	input wire logic fault_out_n_out,
	input wire logic fault_out_n_oe_n,
	input wire logic power_good_out,
	output logic fault_pin,
	output logic [31:0] pg_span
);
	logic [31:0] low_cnt = 32'h0;
	// Board pull-up; the supervisor can only sink the line
	assign fault_pin = fault_out_n_oe_n ? 1'b1 : fault_out_n_out;
	// Power good acts as the controller reset; keep the last low span
	always @(posedge sys_clk) begin
		if (!power_good_out)
			low_cnt <= low_cnt + 32'h1;
		else begin
			if (low_cnt != 32'h0)
				pg_span <= low_cnt;
			low_cnt <= 32'h0;
		end
	end
endmodule

// >>> gds_fault_supervisor_test.sv
`timescale 1ns/1ps
module gds_fault_supervisor_test;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h3;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	gds_pkg::gds_sense_t sense = 14'h0800;
	logic gate_enable = 1'b0;
	logic wake = 1'b0;
	logic fault_pin, fault_out_n_out, fault_out_n_oe_n, power_good_out;
	logic gate_drive_on, gate_pulldown_on, regulator_on;
	logic [1:0] regulator_low_threshold;
	logic [31:0] pg_span;
	logic [31:0] q;
	int err_count = 0;
	int checks_done = 0;
	// Row k: sense bit k raised alone, then warning and fault register images
	logic [10:0] row_w [14] = '{11'h400, 11'h400, 11'h001, 11'h100, 11'h002, 11'h004, 11'h008,
		11'h400, 11'h400, 11'h400, 11'h400, 11'h400, 11'h040, 11'h080};
	logic [10:0] row_f [14] = '{11'h040, 11'h100, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000,
		11'h010, 11'h004, 11'h001, 11'h002, 11'h400, 11'h000, 11'h000};

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	gds_fault_supervisor #(.PG_LOW_CYC(32'h14), .WD_CYC0(32'h3C), .WD_CYC3(32'h78), .SLP_CYC1(32'h14)) dut (
		.sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .sense(sense),
		.gate_enable(gate_enable), .wake(wake), .fault_out_n_in(fault_pin), .fault_out_n_out(fault_out_n_out),
		.fault_out_n_oe_n(fault_out_n_oe_n), .power_good_out(power_good_out), .gate_drive_on(gate_drive_on),
		.gate_pulldown_on(gate_pulldown_on), .regulator_on(regulator_on),
		.regulator_low_threshold(regulator_low_threshold));

	gds_mcu_model mcu (.sys_clk(sys_clk), .fault_out_n_out(fault_out_n_out), .fault_out_n_oe_n(fault_out_n_oe_n),
		.power_good_out(power_good_out), .fault_pin(fault_pin), .pg_span(pg_span));

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20)
			err_count++;
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task print_verdict;
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Whole sequence needs about 1500 cycles
	initial begin
		cyc(20000);
		err_count++;
		print_verdict();
	end

	initial begin
		cyc(8);
		rst <= 1'b0;
		cyc(2);
		rd(8'h38);
		chk("pwrup state", 32'h0, q & 32'h7);
		chk("pwrup pin", 32'h0, 32'(fault_pin));
		rd(8'h24);
		chk("oper reset", 32'h0, q);
		rd(8'h2C);
		chk("regul reset", 32'h0, q);
		rd(8'hFC);
		chk("unmapped", 32'h0, q);
		sense <= '0;
		cyc(10);
		rd(8'h38);
		chk("stby state", 32'h1, q & 32'h7);
		chk("stby pin", 32'h1, 32'(fault_pin));
		for (int k = 13; k >= 0; k--) begin
			gate_enable <= 1'b1;
			cyc(8);
			sense <= gds_pkg::gds_sense_t'(14'h1 << k);
			cyc(8);
			rd(8'h04);
			chk("warn", {21'h0, row_w[k]}, q);
			rd(8'h0C);
			chk("fault", {21'h0, row_f[k]}, q);
			chk("pin", 32'((row_w[k] & 11'h4C1) == 11'h0), 32'(fault_pin));
			chk("drive", 32'(row_f[k] == 11'h0), 32'(gate_drive_on));
			wb(1'b1, 8'h24, 32'h2);
			rd(8'h0C);
			chk("held", {21'h0, row_f[k]}, q);
			sense <= '0;
			gate_enable <= 1'b0;
			cyc(8);
			chk("latch", 32'(row_f[k] == 11'h0), 32'(fault_pin));
			wb(1'b1, 8'h24, 32'h2);
			rd(8'h0C);
			chk("clear", 32'h0, q);
		end
		wb(1'b1, 8'h24, 32'h200);
		gate_enable <= 1'b1;
		cyc(8);
		sense.main_supply_lockout <= 1'b1;
		cyc(8);
		chk("lockout off", 32'h1, 32'(gate_drive_on));
		rd(8'h0C);
		chk("lockout bit", 32'h400, q);
		sense <= '0;
		cyc(8);
		wb(1'b1, 8'h24, 32'h202);
		wb(1'b1, 8'h24, 32'h4);
		rd(8'h38);
		chk("no sleep", 32'h3, q & 32'h7);
		gate_enable <= 1'b0;
		for (int iv = 0; iv < 4; iv += 3) begin
			wb(1'b1, 8'h24, 32'h8 | (iv << 5));
			repeat (3) begin
				cyc(40);
				rd(8'h04);
			end
			cyc(iv ? 100 : 40);
			rd(8'h0C);
			chk("wd early", 32'h0, q);
			cyc(50);
			rd(8'h0C);
			chk("watchdog_expired", 32'h200, q);
			rd(8'h24);
			chk("watchdog_enable off", 32'(iv << 5), q);
			chk("pg span", 32'h1, 32'(pg_span >= 32'h14 && pg_span <= 32'h16));
			wb(1'b1, 8'h24, 32'h2);
		end
		cyc(150);
		rd(8'h0C);
		chk("wd idle", 32'h0, q);
		wb(1'b1, 8'h2C, 32'h4);
		sense.regulator_undervoltage <= 1'b1;
		cyc(8);
		rd(8'h0C);
		chk("monitor off", 32'h0, q);
		sense <= '0;
		wb(1'b1, 8'h2C, 32'h9);
		cyc(2);
		chk("threshold", 32'h1, 32'(regulator_low_threshold));
		wb(1'b1, 8'h24, 32'h4);
		cyc(15);
		chk("sleep wait", 32'h1, 32'(regulator_on));
		cyc(15);
		chk("asleep", 32'h0, 32'(regulator_on));
		sense.main_supply_lockout <= 1'b1;
		wake <= 1'b1;
		cyc(10);
		chk("no wake", 32'h0, 32'(regulator_on));
		sense <= '0;
		cyc(10);
		wake <= 1'b0;
		rd(8'h38);
		chk("woke", 32'h1, q & 32'h7);
		rd(8'h2C);
		chk("erased", 32'h0, q);
		sense.regulator_undervoltage <= 1'b1;
		cyc(8);
		sense <= '0;
		cyc(8);
		gate_enable <= 1'b1;
		cyc(8);
		rd(8'h0C);
		chk("enable clear", 32'h0, q);
		print_verdict();
	end
endmodule
